// ==== design/fml_cfg.svh ====
// offsets, field positions, reset values and fixed counts of the register slice
// assumes it is included by bare name from the package and the design modules
`ifndef FML_CFG_SVH
`define FML_CFG_SVH

// register addresses on the processor port
`define FML_ADDR_FREQ_MEAS 8'h4C
`define FML_ADDR_SOFT_LIMIT 8'h4D
`define FML_ADDR_ALARM_SET 8'h50

// reset values
`define FML_RST_FREQ_MEAS 8'h00
`define FML_RST_SOFT_LIMIT 8'h8E
`define FML_RST_ALARM_SET 8'h06

// soft limit register fields
`define FML_PH_LOSS_BIT 7
`define FML_SOFT_FIELD_MSB 6

// channel select codes that name no input, and the channel and DPLL counts
`define FML_CHAN_NONE_LO 4'h0
`define FML_CHAN_NONE_HI 4'hF
`define FML_NUM_CHAN 14
`define FML_NUM_DPLL 2

// leaky bucket settings held outside this slice, at their reset values
`define FML_LB_ALARM_CLEAR 8'h04
`define FML_LB_BUCKET_SIZE 8'h08
`define FML_LB_DECAY_PERIOD 4'h2

`endif

// ==== design/fml_pkg.sv ====
// types shared by the register slice modules
// assumes fml_cfg.svh is on the include path
`include "fml_cfg.svh"
package fml_pkg;

  // leaky bucket state
  typedef struct packed {
    logic [7:0] count;
    logic [3:0] decay;
    logic alarm;
  } fml_lb_s;

  // register slice state
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] soft_limit;
    logic [7:0] alarm_set;
    logic phase_lost;
    logic [`FML_NUM_DPLL-1:0] soft_alarm;
  } fml_regs_s;

endpackage

// ==== design/fml_lb_if.sv ====
// connection between the register slice and its leaky bucket monitor
// assumes both ends run on the same system clock
interface fml_lb_if;
  logic tick;
  logic fault;
  logic [7:0] set_level;
  logic [7:0] count;
  logic alarm;

  modport bucket (input tick, input fault, input set_level, output count, output alarm);
  modport ctrl (output tick, output fault, output set_level, input count, input alarm);
endinterface

// ==== design/fml_leaky_bucket.sv ====
// leaky bucket activity monitor, configuration 0
// assumes one tick per monitoring cycle, fault valid with the tick
`include "fml_cfg.svh"
module fml_leaky_bucket (
  input wire logic clk_sys,
  input wire logic rst_n,
  fml_lb_if.bucket lb
);

  fml_pkg::fml_lb_s st_q;
  fml_pkg::fml_lb_s st_d;

  // count up on faults, leak one per quiet decay period, hysteresis alarm
  always_comb begin
    st_d = st_q;
    if (lb.tick) begin
      if (lb.fault) begin
        st_d.decay = 4'h0;
        if (st_q.count < `FML_LB_BUCKET_SIZE) begin // bucket saturates at its size
          st_d.count = st_q.count + 8'h01; // RL4
        end
      end else if (st_q.decay + 4'h1 >= `FML_LB_DECAY_PERIOD) begin
        st_d.decay = 4'h0;
        if (st_q.count != 8'h00) begin
          st_d.count = st_q.count - 8'h01; // RL4
        end
      end else begin
        st_d.decay = st_q.decay + 4'h1;
      end
    end
    // set takes precedence over clear should the levels ever overlap
    if (st_d.count >= lb.set_level) begin
      st_d.alarm = 1'b1; // RL5
    end else if (st_d.count <= `FML_LB_ALARM_CLEAR) begin
      st_d.alarm = 1'b0; // RL6
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lb.count = st_q.count;
  assign lb.alarm = st_q.alarm;

endmodule

// ==== design/fml_top.sv ====
// frequency monitor and limit register slice of the timing source
// assumes a synchronous processor port with one-cycle read and write strobes
//
// What this block does
// RL1 - A read register returns the 8-bit signed frequency offset of the channel now selected.
// RL2 - With bit 7 of the soft limit register set, hitting the hard limit forces phase lost.
// RL3 - Each DPLL raises a soft alarm when its offset magnitude exceeds field times 0.628 ppm.
// RL4 - The bucket rises by one per faulty cycle and falls by one per quiet decay period.
// RL5 - The inactivity alarm is raised once the bucket count reaches the set level register.
// RL6 - The inactivity alarm is cleared once the bucket count falls to the clear level.
`include "fml_cfg.svh"
module fml_top (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] CPU_ADDR,
  input wire logic CPU_WR_EN,
  input wire logic CPU_RD_EN,
  input wire logic [7:0] CPU_WDATA,
  output logic [7:0] CPU_RDATA,
  input wire logic [3:0] MEAS_CHAN_SEL,
  input wire logic [`FML_NUM_CHAN*8-1:0] CHAN_FREQ_OFFSET,
  input wire logic [`FML_NUM_DPLL*16-1:0] DPLL_FREQ_OFFSET,
  input wire logic DPLL_HARD_LIMIT_HIT,
  input wire logic LB_CYCLE_TICK,
  input wire logic LB_INPUT_FAULT,
  output logic PHASE_LOST_FORCE,
  output logic [`FML_NUM_DPLL-1:0] SOFT_FREQ_ALARM,
  output logic INACTIVITY_ALARM
);

  fml_pkg::fml_regs_s st_q;
  fml_pkg::fml_regs_s st_d;
  fml_lb_if lb ();
  logic [7:0] meas_sel;
  logic [`FML_NUM_DPLL-1:0] over_limit;

  // leaky bucket runs from the set level register
  assign lb.tick = LB_CYCLE_TICK;
  assign lb.fault = LB_INPUT_FAULT;
  assign lb.set_level = st_q.alarm_set;

  fml_leaky_bucket u_bucket (
    .clk_sys(CLK_SYS),
    .rst_n(RST_N),
    .lb(lb)
  );

  // channel mux; codes 0 and 15 name no input and read back zero
  always_comb begin
    meas_sel = `FML_RST_FREQ_MEAS;
    if (MEAS_CHAN_SEL != `FML_CHAN_NONE_LO && MEAS_CHAN_SEL != `FML_CHAN_NONE_HI) begin
      meas_sel = CHAN_FREQ_OFFSET[(32'(MEAS_CHAN_SEL) - 32'd1) * 8 +: 8]; // RL1
    end
  end

  // per DPLL magnitude compare; offsets are signed counts of 0.628 ppm steps,
  // so the limit compares against the raw field with no multiply
  genvar gi;
  generate
    for (gi = 0; gi < `FML_NUM_DPLL; gi++) begin : g_dpll
      logic [15:0] off;
      logic [15:0] mag;
      assign off = DPLL_FREQ_OFFSET[gi*16 +: 16];
      assign mag = off[15] ? (16'h0000 - off) : off; // 0x8000 maps to 32768, still correct
      assign over_limit[gi] = mag > {9'h000, st_q.soft_limit[`FML_SOFT_FIELD_MSB:0]}; // RL3
    end
  endgenerate

  // register writes, read capture and registered outputs
  always_comb begin
    st_d = st_q;
    if (CPU_WR_EN) begin
      case (CPU_ADDR)
        `FML_ADDR_SOFT_LIMIT: st_d.soft_limit = CPU_WDATA;
        `FML_ADDR_ALARM_SET: st_d.alarm_set = CPU_WDATA;
        default: st_d.soft_limit = st_q.soft_limit; // measurement is not writable
      endcase
    end
    if (CPU_RD_EN) begin
      case (CPU_ADDR)
        `FML_ADDR_FREQ_MEAS: st_d.rdata = meas_sel; // RL1
        `FML_ADDR_SOFT_LIMIT: st_d.rdata = st_q.soft_limit;
        `FML_ADDR_ALARM_SET: st_d.rdata = st_q.alarm_set;
        default: st_d.rdata = 8'h00;
      endcase
    end
    // phase lost follows the hard limit only while the enable bit is set
    st_d.phase_lost = st_q.soft_limit[`FML_PH_LOSS_BIT] & DPLL_HARD_LIMIT_HIT; // RL2
    st_d.soft_alarm = over_limit; // RL3
  end

  // state register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q.rdata <= 8'h00;
      st_q.soft_limit <= `FML_RST_SOFT_LIMIT;
      st_q.alarm_set <= `FML_RST_ALARM_SET;
      st_q.phase_lost <= 1'b0;
      st_q.soft_alarm <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign CPU_RDATA = st_q.rdata;
  assign PHASE_LOST_FORCE = st_q.phase_lost;
  assign SOFT_FREQ_ALARM = st_q.soft_alarm;
  assign INACTIVITY_ALARM = lb.alarm;

endmodule

// ==== bench/fml_top_assertions.sv ====
// port-level checks of the frequency monitor register slice
// assumes a bind onto fml_top; sees only its ports
module fml_top_assertions (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] CPU_ADDR,
  input wire logic CPU_RD_EN,
  input wire logic [7:0] CPU_RDATA,
  input wire logic [3:0] MEAS_CHAN_SEL,
  input wire logic [111:0] CHAN_FREQ_OFFSET,
  input wire logic [31:0] DPLL_FREQ_OFFSET,
  input wire logic DPLL_HARD_LIMIT_HIT,
  input wire logic LB_CYCLE_TICK,
  input wire logic LB_INPUT_FAULT,
  input wire logic PHASE_LOST_FORCE,
  input wire logic [1:0] SOFT_FREQ_ALARM,
  input wire logic INACTIVITY_ALARM
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // read strobe on one address, and a bucket tick of either kind
  sequence s_rd(logic [7:0] a);
    CPU_RD_EN && CPU_ADDR == a;
  endsequence
  sequence s_tick(logic f);
    LB_CYCLE_TICK && LB_INPUT_FAULT == f;
  endsequence
  a_meas_sel_read: assert property (
    s_rd(8'h4C) ##0 MEAS_CHAN_SEL inside {[4'h1:4'hE]} |=> CPU_RDATA ==
    8'($past(CHAN_FREQ_OFFSET) >> (8 * ($past(MEAS_CHAN_SEL) - 1))))
    else $error("measurement read wrong");
  a_rdata_holds: assert property (!CPU_RD_EN |=> $stable(CPU_RDATA))
    else $error("read data moved");
  a_unmapped_zero: assert property (s_rd(8'h00) |=> CPU_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_lost_needs_hit: assert property (PHASE_LOST_FORCE |-> $past(DPLL_HARD_LIMIT_HIT))
    else $error("phase lost without hard limit");
  a_zero_no_alarm: assert property (
    $past(DPLL_FREQ_OFFSET[15:0]) == 16'h0000 |-> !SOFT_FREQ_ALARM[0])
    else $error("alarm at zero offset");
  a_rise_on_fault: assert property (
    $rose(INACTIVITY_ALARM) |-> $past(LB_CYCLE_TICK && LB_INPUT_FAULT))
    else $error("alarm rose without fault");
  a_fall_on_quiet: assert property (
    $fell(INACTIVITY_ALARM) |-> $past(LB_CYCLE_TICK && !LB_INPUT_FAULT))
    else $error("alarm fell without quiet tick");
endmodule

bind fml_top fml_top_assertions i_fml_top_assertions (.*);

// ==== bench/fml_top_tb_top.sv ====
// self-checking bench of the frequency monitor register slice
// assumes fml_top with its checker bound in
module fml_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, RST_N = 0, CPU_WR_EN = 0, CPU_RD_EN = 0, DPLL_HARD_LIMIT_HIT = 0;
  logic LB_CYCLE_TICK = 0, LB_INPUT_FAULT = 0, PHASE_LOST_FORCE, INACTIVITY_ALARM;
  logic [7:0] CPU_ADDR = 8'h00, CPU_WDATA = 8'h00, CPU_RDATA;
  logic [3:0] MEAS_CHAN_SEL = 4'h0;
  logic [111:0] CHAN_FREQ_OFFSET;
  logic [31:0] DPLL_FREQ_OFFSET = 32'h0;
  logic [1:0] SOFT_FREQ_ALARM;
  int err_count = 0, checked = 0;
  typedef struct {logic [7:0] a; logic [3:0] s; logic [7:0] e;} fml_row_s;
  fml_row_s rows[5] = '{'{8'h4D, 4'h0, 8'h8E}, '{8'h50, 4'h0, 8'h06},
    '{8'h4C, 4'h3, 8'h83}, '{8'h4C, 4'hE, 8'h8E}, '{8'h00, 4'h0, 8'h00}};
  fml_top i_fml_top (.*);
  // clock, and channel n reporting 0x80 plus n
  initial begin
    for (int n = 1; n <= 14; n++) CHAN_FREQ_OFFSET[(n-1)*8 +: 8] = 8'h80 + 8'(n);
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one strobe, released at the edge that takes it
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge CLK_SYS);
    CPU_ADDR <= a;
    CPU_WDATA <= d;
    CPU_WR_EN <= w;
    CPU_RD_EN <= !w;
    @(posedge CLK_SYS);
    CPU_WR_EN <= 1'b0;
    CPU_RD_EN <= 1'b0;
    #1;
  endtask
  // spaced ticks leave idle cycles; the alarm flop loads on the same edge as the count
  task automatic tick(logic f);
    @(posedge CLK_SYS);
    LB_CYCLE_TICK <= 1'b1;
    LB_INPUT_FAULT <= f;
    @(posedge CLK_SYS);
    LB_CYCLE_TICK <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic mon(logic h, logic [15:0] o);
    @(posedge CLK_SYS);
    DPLL_HARD_LIMIT_HIT <= h;
    DPLL_FREQ_OFFSET <= {o, o}; // both trackers see the same offset
    @(posedge CLK_SYS);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog well beyond the 80 or so cycles the tests need
  initial begin
    repeat (2000) @(posedge CLK_SYS);
    err_count++;
    report_and_stop();
  end
  // reset, table of reads, then hand-written cases
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    foreach (rows[i]) begin
      MEAS_CHAN_SEL <= rows[i].s;
      bus(0, rows[i].a, 8'h00);
      chk("read", rows[i].e, CPU_RDATA);
    end
    MEAS_CHAN_SEL <= 4'hE;
    bus(1, 8'h4C, 8'h55);
    bus(1, 8'h50, 8'h03);
    bus(0, 8'h4C, 8'h00);
    chk("meas after write", 8'h8E, CPU_RDATA);
    bus(0, 8'h50, 8'h00);
    chk("set level", 8'h03, CPU_RDATA);
    bus(1, 8'h50, 8'h06);
    mon(1, 16'd15);
    chk("lost on", 8'h01, 8'(PHASE_LOST_FORCE));
    chk("alarm 15", 8'h03, 8'(SOFT_FREQ_ALARM));
    bus(1, 8'h4D, 8'h0F);
    mon(1, 16'hFFF0);
    chk("lost off", 8'h00, 8'(PHASE_LOST_FORCE));
    chk("alarm -16", 8'h03, 8'(SOFT_FREQ_ALARM));
    mon(0, 16'd15);
    chk("edge 15", 8'h00, 8'(SOFT_FREQ_ALARM));
    for (int i = 1; i <= 6; i++) begin
      tick(1);
      chk("fault", 8'(i == 6), 8'(INACTIVITY_ALARM));
    end
    for (int i = 1; i <= 2; i++) begin
      tick(0);
      tick(0);
      chk("decay", 8'(i < 2), 8'(INACTIVITY_ALARM));
    end
    report_and_stop();
  end
endmodule
